// ==== rtl/clp_pkg.sv ====
// constants, types and settings for the cold load pickup logic
// Notes on behaviour
// - cold detection follows one selected mode: breaker open, undercurrent, both, or either.
// - a recognised cold condition starts the load-off delay timer.
// - when the load-off delay expires the cold load enable output is raised.
// - the end of the cold condition starts inrush supervision.
// - inrush is present when measured current rises above the inrush threshold.
// - inrush is over once current has fallen to ninety percent of the threshold.
// - after inrush ends a settle timer runs and enable drops when it or the max block timer expires.
// - a max block timer runs beside inrush supervision and its expiry ends enable.
// - the max block timer stops when current stays below 0.9 of threshold for the settle time.
// - the external or internal block input chosen by block select inhibits the function.
// - a running auto-reclose sequence blocks the function.
// - the function only gives an enable signal and never a trip command.
package clp_pkg;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_T_OFF    = 8'h04;
    localparam logic [7:0] ADDR_T_SETTLE = 8'h08;
    localparam logic [7:0] ADDR_T_MAXBLK = 8'h0c;
    localparam logic [7:0] ADDR_I_INRUSH = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;
    // ctrl fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FUNC_ON   = 2;
    localparam int CTRL_BLK_SEL   = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    // irq bits
    localparam int IRQ_ON  = 0;
    localparam int IRQ_OFF = 1;
    localparam int IRQ_MAX = 2;
    localparam int IRQ_W   = 3;
    // inrush dropout ratio 9/10
    localparam int RATIO_NUM = 9;
    localparam int RATIO_DEN = 10;
    localparam logic [31:0] T_RESET = 32'h0000_0064;
    localparam logic [15:0] I_RESET = 16'h0100;
    typedef enum logic [1:0] {
        MODE_BKR,
        MODE_UC,
        MODE_AND,
        MODE_OR
    } clp_mode_t;
    typedef enum {
        ST_WARM,
        ST_LOADOFF,
        ST_COLD,
        ST_RECOVER
    } clp_state_t;
endpackage : clp_pkg

// ==== rtl/clp_timer_if.sv ====
// interface carrying one delay timer's controls and result
`timescale 1ns/1ps
interface clp_timer_if #(parameter int W = 32);
    logic         run;
    logic [W-1:0] preset;
    logic         done;
    modport owner (output run, output preset, input done);
    modport timer (input run, input preset, output done);
endinterface : clp_timer_if

// ==== rtl/clp_timer.sv ====
// tick counting delay timer that clears when not running
`timescale 1ns/1ps
module clp_timer #(parameter int W = 32) (
    input  wire logic   clock,
    input  wire logic   resetn,
    input  wire logic   ce,
    clp_timer_if.timer  tif
);
    logic [W-1:0] cnt_r;
    logic         done_r;
    assign tif.done = done_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            if (!tif.run) begin
                cnt_r  <= '0;
                done_r <= 1'b0;
            end else if (!done_r) begin
                // preset 0 or 1 both expire after one tick
                if (cnt_r + 1'b1 >= tif.preset) begin
                    done_r <= 1'b1;
                end
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : clp_timer

// ==== rtl/clp_cold_load.sv ====
// cold load pickup supervision with register port and interrupt
`timescale 1ns/1ps
module clp_cold_load #(
    parameter int IW = 16,
    parameter int TW = 32
) (
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          breaker_position,
    input  wire logic          cold_undercurrent_flag,
    input  wire logic [IW-1:0] load_current,
    input  wire logic          ext_block,
    input  wire logic          int_block,
    input  wire logic          auto_reclose_running,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic [31:0]        rdata,
    output logic               cold_load_enable_out,
    output logic               inrush_out,
    output logic               irq
);
    logic [31:0]   ctrl_r;
    logic [TW-1:0] t_off_r;
    logic [TW-1:0] t_settle_r;
    logic [TW-1:0] t_max_r;
    logic [IW-1:0] i_inrush_r;
    logic [clp_pkg::IRQ_W-1:0] irq_stat_r;
    logic [clp_pkg::IRQ_W-1:0] irq_en_r;
    clp_pkg::clp_state_t state_r;
    clp_pkg::clp_state_t state_nxt;
    logic inrush_r;
    logic inrush_seen_r;
    logic maxblk_stop_r;
    logic blocked;
    logic cold_cond;
    logic above_thr;
    logic below_drop;
    logic [clp_pkg::IRQ_W-1:0] ev;

    clp_timer_if #(.W(TW)) off_if ();
    clp_timer_if #(.W(TW)) set_if ();
    clp_timer_if #(.W(TW)) max_if ();
    clp_timer #(.W(TW)) u_off (.clock(clock), .resetn(resetn), .ce(ce), .tif(off_if));
    clp_timer #(.W(TW)) u_set (.clock(clock), .resetn(resetn), .ce(ce), .tif(set_if));
    clp_timer #(.W(TW)) u_max (.clock(clock), .resetn(resetn), .ce(ce), .tif(max_if));

    // widened compare avoids overflow of current times ten
    function automatic logic at_or_below_ratio(input logic [IW-1:0] i, input logic [IW-1:0] t);
        logic [IW+4:0] lhs;
        logic [IW+4:0] rhs;
        lhs = (IW+5)'(i) * (IW+5)'(clp_pkg::RATIO_DEN);
        rhs = (IW+5)'(t) * (IW+5)'(clp_pkg::RATIO_NUM);
        return lhs <= rhs;
    endfunction : at_or_below_ratio

    function automatic logic mode_cold(input logic [1:0] m, input logic bkr_open,
                                       input logic uc);
        case (clp_pkg::clp_mode_t'(m))
            clp_pkg::MODE_BKR: return bkr_open;
            clp_pkg::MODE_UC:  return uc;
            clp_pkg::MODE_AND: return bkr_open & uc;
            clp_pkg::MODE_OR:  return bkr_open | uc;
            default:           return 1'b0;
        endcase
    endfunction : mode_cold

    // breaker_position high means closed
    assign cold_cond = mode_cold(ctrl_r[clp_pkg::CTRL_MODE_LSB +: 2],
                                 ~breaker_position, cold_undercurrent_flag);
    // block select: 1 uses the internal source, 0 the external one
    assign blocked = ~ctrl_r[clp_pkg::CTRL_FUNC_ON]
                   | (ctrl_r[clp_pkg::CTRL_BLK_SEL] ? int_block : ext_block)
                   | auto_reclose_running;
    assign above_thr  = load_current > i_inrush_r;
    assign below_drop = at_or_below_ratio(load_current, i_inrush_r);

    assign off_if.preset = t_off_r;
    assign set_if.preset = t_settle_r;
    assign max_if.preset = t_max_r;
    assign off_if.run = !blocked && state_r == clp_pkg::ST_LOADOFF && cold_cond;
    // settle runs while current sits low after an inrush, or no inrush came
    assign set_if.run = !blocked && state_r == clp_pkg::ST_RECOVER && !inrush_r
                      && below_drop;
    assign max_if.run = !blocked && state_r == clp_pkg::ST_RECOVER && !maxblk_stop_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            clp_pkg::ST_WARM: begin
                if (cold_cond) begin
                    state_nxt = clp_pkg::ST_LOADOFF;
                end
            end
            clp_pkg::ST_LOADOFF: begin
                if (!cold_cond) begin
                    state_nxt = clp_pkg::ST_WARM;
                end else if (off_if.done) begin
                    state_nxt = clp_pkg::ST_COLD;
                end
            end
            clp_pkg::ST_COLD: begin
                if (!cold_cond) begin
                    state_nxt = clp_pkg::ST_RECOVER;
                end
            end
            clp_pkg::ST_RECOVER: begin
                if (cold_cond) begin
                    state_nxt = clp_pkg::ST_COLD;
                end else if (set_if.done || max_if.done) begin
                    state_nxt = clp_pkg::ST_WARM;
                end
            end
            default: state_nxt = clp_pkg::ST_WARM;
        endcase
        if (blocked) begin
            state_nxt = clp_pkg::ST_WARM;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= clp_pkg::ST_WARM;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // inrush detector with hysteresis
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            inrush_r      <= 1'b0;
            inrush_seen_r <= 1'b0;
        end else if (ce) begin
            if (blocked || state_r != clp_pkg::ST_RECOVER) begin
                inrush_r      <= 1'b0;
                inrush_seen_r <= 1'b0;
            end else if (above_thr) begin
                inrush_r      <= 1'b1;
                inrush_seen_r <= 1'b1;
            end else if (below_drop) begin
                inrush_r <= 1'b0;
            end
        end
    end

    // once settled, max block stops and settle alone ends enable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            maxblk_stop_r <= 1'b0;
        end else if (ce) begin
            if (blocked || state_r != clp_pkg::ST_RECOVER) begin
                maxblk_stop_r <= 1'b0;
            end else if (set_if.done) begin
                maxblk_stop_r <= 1'b1;
            end
        end
    end

    // only an enable and the inrush flag leave the block; no trip path exists
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cold_load_enable_out <= 1'b0;
            inrush_out           <= 1'b0;
        end else if (ce) begin
            cold_load_enable_out <= state_nxt == clp_pkg::ST_COLD
                                 || state_nxt == clp_pkg::ST_RECOVER;
            inrush_out <= inrush_r;
        end
    end

    // configuration registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_r     <= clp_pkg::CTRL_RESET;
            t_off_r    <= TW'(clp_pkg::T_RESET);
            t_settle_r <= TW'(clp_pkg::T_RESET);
            t_max_r    <= TW'(clp_pkg::T_RESET);
            i_inrush_r <= IW'(clp_pkg::I_RESET);
            irq_en_r   <= '0;
        end else if (ce && wr) begin
            case (addr)
                clp_pkg::ADDR_CTRL:     ctrl_r     <= wdata & 32'h0000_000f;
                clp_pkg::ADDR_T_OFF:    t_off_r    <= wdata[TW-1:0];
                clp_pkg::ADDR_T_SETTLE: t_settle_r <= wdata[TW-1:0];
                clp_pkg::ADDR_T_MAXBLK: t_max_r    <= wdata[TW-1:0];
                clp_pkg::ADDR_I_INRUSH: i_inrush_r <= wdata[IW-1:0];
                clp_pkg::ADDR_IRQ_EN:   irq_en_r   <= wdata[clp_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events: set wins over a same-cycle clear
    assign ev[clp_pkg::IRQ_ON]  = !cold_load_enable_out && state_nxt == clp_pkg::ST_COLD;
    assign ev[clp_pkg::IRQ_OFF] = cold_load_enable_out && state_nxt == clp_pkg::ST_WARM;
    assign ev[clp_pkg::IRQ_MAX] = max_if.done && state_r == clp_pkg::ST_RECOVER;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_stat_r <= '0;
            irq        <= 1'b0;
        end else if (ce) begin
            if (wr && addr == clp_pkg::ADDR_IRQ_CLR) begin
                irq_stat_r <= (irq_stat_r & ~wdata[clp_pkg::IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            irq <= |(irq_stat_r & irq_en_r);
        end
    end

    // read port: data valid in the cycle after rd
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd) begin
                case (addr)
                    clp_pkg::ADDR_CTRL:     rdata <= ctrl_r;
                    clp_pkg::ADDR_T_OFF:    rdata <= 32'(t_off_r);
                    clp_pkg::ADDR_T_SETTLE: rdata <= 32'(t_settle_r);
                    clp_pkg::ADDR_T_MAXBLK: rdata <= 32'(t_max_r);
                    clp_pkg::ADDR_I_INRUSH: rdata <= 32'(i_inrush_r);
                    clp_pkg::ADDR_STATUS:   rdata <= {26'h0, inrush_seen_r, maxblk_stop_r,
                                                      inrush_r, blocked,
                                                      cold_load_enable_out, cold_cond};
                    clp_pkg::ADDR_IRQ_STAT: rdata <= 32'(irq_stat_r);
                    clp_pkg::ADDR_IRQ_EN:   rdata <= 32'(irq_en_r);
                    default:                rdata <= '0;
                endcase
            end
        end
    end

    property p_block_clears;
        @(posedge clock) disable iff (!resetn)
        (ce && blocked) |=> !cold_load_enable_out;
    endproperty
    a_block_clears: assert property (p_block_clears) else $error("enable while blocked");

    property p_ar_blocks;
        @(posedge clock) disable iff (!resetn)
        (ce && auto_reclose_running) |=> state_r == clp_pkg::ST_WARM;
    endproperty
    a_ar_blocks: assert property (p_ar_blocks) else $error("active during reclose");

    property p_enable_on_expiry;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_LOADOFF && cold_cond && off_if.done)
        |=> cold_load_enable_out;
    endproperty
    a_enable_on_expiry: assert property (p_enable_on_expiry) else $error("no enable");

    property p_off_needs_timer;
        @(posedge clock) disable iff (!resetn)
        (ce && $rose(cold_load_enable_out)) |-> $past(off_if.done) || $past(state_r)
                                              != clp_pkg::ST_LOADOFF;
    endproperty
    a_off_needs_timer: assert property (p_off_needs_timer) else $error("early enable");

    property p_recover_on_warm;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_COLD && !cold_cond)
        |=> state_r == clp_pkg::ST_RECOVER && cold_load_enable_out;
    endproperty
    a_recover_on_warm: assert property (p_recover_on_warm) else $error("no recover");

    property p_inrush_set;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_RECOVER && above_thr) |=> inrush_r;
    endproperty
    a_inrush_set: assert property (p_inrush_set) else $error("inrush missed");

    property p_inrush_hold;
        @(posedge clock) disable iff (!resetn)
        (ce && inrush_r && !below_drop && !blocked && state_r == clp_pkg::ST_RECOVER)
        |=> inrush_r;
    endproperty
    a_inrush_hold: assert property (p_inrush_hold) else $error("inrush dropped early");

    property p_drop_needs_timer;
        @(posedge clock) disable iff (!resetn)
        (ce && $past(ce) && $fell(cold_load_enable_out) && !$past(blocked)
         && $past(state_r) == clp_pkg::ST_RECOVER)
        |-> $past(set_if.done) || $past(max_if.done);
    endproperty
    a_drop_needs_timer: assert property (p_drop_needs_timer) else $error("early drop");

    property p_max_stopped;
        @(posedge clock) disable iff (!resetn)
        (ce && maxblk_stop_r) |=> !max_if.done;
    endproperty
    a_max_stopped: assert property (p_max_stopped) else $error("max block still runs");

    property p_warm_to_loadoff;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_WARM && cold_cond)
        |=> state_r == clp_pkg::ST_LOADOFF && !cold_load_enable_out;
    endproperty
    a_warm_to_loadoff: assert property (p_warm_to_loadoff) else $error("cold missed");

    property p_loadoff_abort;
        @(posedge clock) disable iff (!resetn)
        (ce && state_r == clp_pkg::ST_LOADOFF && !cold_cond)
        |=> state_r == clp_pkg::ST_WARM && !cold_load_enable_out;
    endproperty
    a_loadoff_abort: assert property (p_loadoff_abort) else $error("restart missed");

    property p_settle_ends;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_RECOVER && !cold_cond && set_if.done)
        |=> !cold_load_enable_out;
    endproperty
    a_settle_ends: assert property (p_settle_ends) else $error("kept after settle");

    property p_max_ends;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_RECOVER && !cold_cond && max_if.done)
        |=> !cold_load_enable_out;
    endproperty
    a_max_ends: assert property (p_max_ends) else $error("kept after max block");

    property p_settle_waits;
        @(posedge clock) disable iff (!resetn)
        (ce && inrush_r) |=> !set_if.done;
    endproperty
    a_settle_waits: assert property (p_settle_waits) else $error("settle during inrush");

    property p_inrush_end;
        @(posedge clock) disable iff (!resetn)
        (ce && !blocked && state_r == clp_pkg::ST_RECOVER && !above_thr && below_drop)
        |=> !inrush_r;
    endproperty
    a_inrush_end: assert property (p_inrush_end) else $error("inrush not ended");

    property p_timers_clear;
        @(posedge clock) disable iff (!resetn)
        (ce && blocked) |=> !off_if.done && !set_if.done && !max_if.done;
    endproperty
    a_timers_clear: assert property (p_timers_clear) else $error("timer kept on block");

    property p_max_event;
        @(posedge clock) disable iff (!resetn)
        (ce && state_r == clp_pkg::ST_RECOVER && max_if.done) |=> irq_stat_r[clp_pkg::IRQ_MAX];
    endproperty
    a_max_event: assert property (p_max_event) else $error("max event lost");
endmodule : clp_cold_load

// ==== bench/clp_oc_model.sv ====
// overcurrent element model that desensitises while cold load enable is high
`timescale 1ns/1ps
module clp_oc_model #(
    parameter int LO = 80,
    parameter int HI = 400
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        enable,
    input  wire logic [15:0] current,
    output logic             oc_trip
);
    // the trip decision lives here, the cold load block only lends its enable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            oc_trip <= 1'b0;
        else
            oc_trip <= current > (enable ? HI : LO);
    end
endmodule : clp_oc_model

// ==== bench/test_clp_cold_load.sv ====
// self-checking bench for the cold load pickup logic
`timescale 1ns/1ps
module test_clp_cold_load;
    typedef struct packed {logic [1:0] mode; logic bkr; logic uc; logic en;} clp_mode_row_t;
    typedef struct packed {logic [7:0] a; logic [31:0] d;} clp_reg_row_t;
    logic        clock, resetn, ce, breaker_position, cold_undercurrent_flag;
    logic        ext_block, int_block, auto_reclose_running, wr, rd;
    logic        cold_load_enable_out, inrush_out, irq, oc_trip;
    logic [15:0] load_current;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    int          fail_count, n_compared, n;
    // mode, breaker closed, undercurrent, expected enable
    clp_mode_row_t rows [12] = '{5'h01, 5'h06, 5'h03, 5'h08, 5'h0f, 5'h0b,
                                 5'h10, 5'h16, 5'h13, 5'h19, 5'h1f, 5'h1b};
    clp_reg_row_t regs [10] = '{
        {clp_pkg::ADDR_CTRL, clp_pkg::CTRL_RESET}, {clp_pkg::ADDR_T_OFF, clp_pkg::T_RESET},
        {clp_pkg::ADDR_T_SETTLE, clp_pkg::T_RESET}, {clp_pkg::ADDR_T_MAXBLK, clp_pkg::T_RESET},
        {clp_pkg::ADDR_I_INRUSH, {16'h0000, clp_pkg::I_RESET}}, {clp_pkg::ADDR_STATUS, 32'h0},
        {clp_pkg::ADDR_IRQ_STAT, 32'h0}, {clp_pkg::ADDR_IRQ_EN, 32'h0},
        {clp_pkg::ADDR_IRQ_CLR, 32'h0}, {8'h24, 32'h0}};

    clp_cold_load clp_cold_load_i (.clock(clock), .resetn(resetn), .ce(ce),
        .breaker_position(breaker_position), .cold_undercurrent_flag(cold_undercurrent_flag),
        .load_current(load_current), .ext_block(ext_block), .int_block(int_block),
        .auto_reclose_running(auto_reclose_running), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cold_load_enable_out(cold_load_enable_out),
        .inrush_out(inrush_out), .irq(irq));
    clp_oc_model clp_oc_model_i (.clock(clock), .resetn(resetn),
        .enable(cold_load_enable_out), .current(load_current), .oc_trip(oc_trip));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatches", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask : rd_reg

    task automatic set_in(input logic b, input logic u, input logic [15:0] c);
        @(posedge clock);
        breaker_position <= b;
        cold_undercurrent_flag <= u;
        load_current <= c;
    endtask : set_in

    task automatic set_blk(input logic [2:0] b);
        @(posedge clock);
        {auto_reclose_running, int_block, ext_block} <= b;
    endtask : set_blk

    // a hang here would hide every later test, so the bound ends the run
    task automatic wait_en(input logic val, input int lim);
        n = 0;
        @(negedge clock);
        while (cold_load_enable_out !== val) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                fail_count++;
                $display("mismatch at %0t: enable wait ran out", $time);
                complete_run();
            end
        end
    endtask : wait_en

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        breaker_position = 1'b1;
        cold_undercurrent_flag = 1'b0;
        load_current = 16'h0000;
        {auto_reclose_running, int_block, ext_block} = 3'h0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (2) @(negedge clock);
        check({cold_load_enable_out, inrush_out, irq, rdata}, 35'h0);
        @(posedge clock);
        resetn <= 1'b1;
        foreach (regs[i]) begin
            rd_reg(regs[i].a, v);
            check(v, regs[i].d);
        end
        $display("test reset values done");
        wr_reg(clp_pkg::ADDR_T_OFF, 32'h3);
        wr_reg(clp_pkg::ADDR_T_SETTLE, 32'h4);
        wr_reg(clp_pkg::ADDR_T_MAXBLK, 32'h28);
        wr_reg(clp_pkg::ADDR_I_INRUSH, 32'h64);
        foreach (rows[i]) begin
            wr_reg(clp_pkg::ADDR_CTRL, {28'h0, 2'b01, rows[i].mode});
            set_in(rows[i].bkr, rows[i].uc, 16'h0000);
            repeat (10) @(negedge clock);
            check(cold_load_enable_out, rows[i].en);
            set_in(1'b1, 1'b0, 16'h0000);
            repeat (12) @(negedge clock);
            check(cold_load_enable_out, 1'b0);
        end
        $display("test detection modes done");
        wr_reg(clp_pkg::ADDR_CTRL, 32'h4);
        set_in(1'b0, 1'b0, 16'h0000);
        set_in(1'b1, 1'b0, 16'h0000);
        repeat (10) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        set_in(1'b0, 1'b0, 16'h0000);
        wait_en(1'b1, 12);
        check(n >= 4 && n <= 8, 1'b1);
        $display("test load-off delay done");
        // threshold itself is not inrush, one step above is
        set_in(1'b1, 1'b0, 16'h0064);
        repeat (3) @(negedge clock);
        check(inrush_out, 1'b0);
        set_in(1'b1, 1'b0, 16'h0065);
        repeat (3) @(negedge clock);
        check({inrush_out, oc_trip}, 2'b10);
        set_in(1'b1, 1'b0, 16'h005b);
        repeat (6) @(negedge clock);
        check({inrush_out, cold_load_enable_out}, 2'b11);
        set_in(1'b1, 1'b0, 16'h005a);
        repeat (3) @(negedge clock);
        check({inrush_out, cold_load_enable_out}, 2'b01);
        wait_en(1'b0, 10);
        repeat (2) @(negedge clock);
        check(oc_trip, 1'b1);
        set_in(1'b1, 1'b0, 16'h0000);
        $display("test inrush and settle done");
        set_in(1'b0, 1'b0, 16'h0000);
        wait_en(1'b1, 12);
        set_in(1'b1, 1'b0, 16'h00c8);
        repeat (30) @(negedge clock);
        check(cold_load_enable_out, 1'b1);
        wait_en(1'b0, 20);
        set_in(1'b1, 1'b0, 16'h0000);
        rd_reg(clp_pkg::ADDR_IRQ_STAT, v);
        check({v, irq}, {32'h7, 1'b0});
        wr_reg(clp_pkg::ADDR_IRQ_EN, 32'h7);
        repeat (2) @(negedge clock);
        check(irq, 1'b1);
        wr_reg(clp_pkg::ADDR_IRQ_CLR, 32'h7);
        repeat (2) @(negedge clock);
        check(irq, 1'b0);
        $display("test max block and irq done");
        set_in(1'b0, 1'b0, 16'h0000);
        wait_en(1'b1, 12);
        set_blk(3'h1);
        repeat (3) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        repeat (10) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        set_blk(3'h2);
        repeat (8) @(negedge clock);
        check(cold_load_enable_out, 1'b1);
        wr_reg(clp_pkg::ADDR_CTRL, 32'hc);
        repeat (3) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        set_blk(3'h4);
        repeat (8) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        set_blk(3'h0);
        wait_en(1'b1, 12);
        $display("test blocking done");
        set_in(1'b1, 1'b0, 16'h0000);
        wait_en(1'b0, 15);
        @(posedge clock);
        ce <= 1'b0;
        wr_reg(clp_pkg::ADDR_T_OFF, 32'h5);
        set_in(1'b0, 1'b0, 16'h0000);
        repeat (10) @(negedge clock);
        check(cold_load_enable_out, 1'b0);
        @(posedge clock);
        ce <= 1'b1;
        rd_reg(clp_pkg::ADDR_T_OFF, v);
        check(v, 32'h3);
        wait_en(1'b1, 12);
        $display("test clock enable done");
        // a reset in mid-run must drop enable at once and restore the presets
        @(posedge clock);
        resetn <= 1'b0;
        @(negedge clock);
        check({cold_load_enable_out, inrush_out, irq}, 3'h0);
        @(posedge clock);
        resetn <= 1'b1;
        rd_reg(clp_pkg::ADDR_T_OFF, v);
        check({v, cold_load_enable_out}, {clp_pkg::T_RESET, 1'b0});
        $display("test reset in run done");
        complete_run();
    end
endmodule : test_clp_cold_load
